// ==== inc/oaddr_consts.vh ====
`ifndef OADDR_CONSTS_VH
`define OADDR_CONSTS_VH

// register byte addresses
`define OA_OFF_WREG 32'h00000000
`define OA_OFF_PAIR 32'h00000004
`define OA_OFF_CTRL 32'h00000008
`define OA_OFF_PC 32'h0000000C
`define OA_OFF_REQ 32'h00000010
`define OA_OFF_RES 32'h00000014
`define OA_OFF_BOP 32'h00000018
`define OA_OFF_SKIP 32'h0000001C

`define OA_RESP_OKAY 2'h0
`define OA_RESP_SLVERR 2'h2

// control word fields
`define OA_CTL_CY 0
`define OA_CTL_MBE 1
`define OA_CTL_MBS_LO 4
`define OA_CTL_PCC_LO 8

// request, bit-op and skip fields
`define OA_REQ_KIND_LO 16
`define OA_BOP_SEL_LO 2
`define OA_BOP_BIT_LO 5
`define OA_SKIP_TABLE_INDIRECT_CALL 2

// operand kinds
`define OA_K_DIRECT 4'h0
`define OA_K_IND_HL 4'h1
`define OA_K_IND_DE 4'h2
`define OA_K_FMEM 4'h3
`define OA_K_PMEM 4'h4
`define OA_K_ABS 4'h5
`define OA_K_REL 4'h6
`define OA_K_CADDR 4'h7
`define OA_K_FADDR 4'h8
`define OA_K_TADDR 4'h9

`define OA_BANK0 4'h0
`define OA_BANK1 4'h1
`define OA_BANK15 4'hF

`define OA_FMEM_A_LO 12'hFB0
`define OA_FMEM_A_HI 12'hFBF
`define OA_FMEM_B_LO 12'hFF0
`define OA_PMEM_LO 12'hFC0
`define OA_PROG_MAX 13'h1F7F
`define OA_TADDR_LO 13'h0020
`define OA_TADDR_HI 13'h007F
`define OA_REL_FWD_MIN 14'h0002
`define OA_REL_FWD_MAX 14'h0010
`define OA_REL_BACK_MIN 14'h3FF1

// bit operations on the carry
`define OA_BOP_LD 2'h0
`define OA_BOP_AND 2'h1
`define OA_BOP_OR 2'h2
`define OA_BOP_XOR 2'h3

// skip lengths and extra machine cycles
`define OA_LEN_NONE 2'h0
`define OA_LEN_LONG 2'h3
`define OA_S_NONE 2'h0
`define OA_S_SHORT 2'h1
`define OA_S_LONG 2'h2

// machine-cycle divider settings
`define OA_PCC_SLOW 2'h0
`define OA_PCC_MID 2'h1
`define OA_PCC_FAST 2'h2
`define OA_PCC_BAD 2'h3
`define OA_DIV_SLOW 8'h3F
`define OA_DIV_MID 8'h0F
`define OA_DIV_FAST 8'h03

`endif

// ==== core/oaddr_decode.v ====
`timescale 1ns/1ns
`include "oaddr_consts.vh"

module oaddr_decode (
   input wire [3:0] kind,
   input wire [12:0] oper,
   input wire [12:0] pc,
   input wire bank_enable_flag,
   input wire [3:0] bank_select_value,
   input wire [7:0] hl,
   input wire [7:0] de,
   input wire [7:0] dl,
   output reg [3:0] bank,
   output reg [12:0] addr,
   output reg legal,
   output reg is_data
);
   reg [13:0] diff;
   reg [12:0] blk;

   always @* begin
      diff = {1'b0, oper} - {1'b0, pc};
      blk = {pc[12], oper[11:0]};
      bank = `OA_BANK0;
      addr = {5'h00, oper[7:0]};
      legal = 1'b0;
      is_data = 1'b1;
      case (kind)
         `OA_K_DIRECT: begin
            bank = bank_enable_flag ? bank_select_value : (oper[7] ? `OA_BANK15 : `OA_BANK0);
            legal = (oper[12:8] == 5'h00);
         end
         `OA_K_IND_HL: begin
            bank = bank_enable_flag ? bank_select_value : `OA_BANK0;
            addr = {5'h00, hl};
            legal = 1'b1;
         end
         `OA_K_IND_DE: begin
            addr = {5'h00, oper[0] ? dl : de};
            legal = 1'b1;
         end
         `OA_K_FMEM: begin
            bank = `OA_BANK15;
            legal = !oper[12] && ((oper[11:0] >= `OA_FMEM_A_LO && oper[11:0] <= `OA_FMEM_A_HI)
               || oper[11:0] >= `OA_FMEM_B_LO);
         end
         `OA_K_PMEM: begin
            bank = `OA_BANK15;
            legal = !oper[12] && oper[11:0] >= `OA_PMEM_LO;
         end
         `OA_K_ABS: begin
            is_data = 1'b0;
            addr = oper;
            legal = oper <= `OA_PROG_MAX;
         end
         `OA_K_REL: begin
            is_data = 1'b0;
            addr = oper;
            legal = (diff >= `OA_REL_FWD_MIN && diff <= `OA_REL_FWD_MAX)
               || diff >= `OA_REL_BACK_MIN;
         end
         `OA_K_CADDR: begin
            is_data = 1'b0;
            addr = blk;
            legal = !oper[12] && blk <= `OA_PROG_MAX;
         end
         `OA_K_FADDR: begin
            is_data = 1'b0;
            addr = {2'h0, oper[10:0]};
            legal = (oper[12:11] == 2'h0);
         end
         `OA_K_TADDR: begin
            is_data = 1'b0;
            addr = oper;
            legal = oper >= `OA_TADDR_LO && oper <= `OA_TADDR_HI && !oper[0];
         end
         default: begin
            legal = 1'b0;
         end
      endcase
      if (is_data) begin
         addr = {1'b0, bank, addr[7:0]};
      end
   end
endmodule

// ==== core/oaddr_core.v ====
// Local design decisions: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ns
`include "oaddr_consts.vh"

// Contract
// - eight 4-bit working registers, accumulator included, usable as operands
// - pairs acc, counter, index and pointer act as 8-bit operands
// - carry is the arithmetic carry and the one-bit accumulator
// - direct operand, bank flag clear: 00H-7FH bank 0, 80H-FFH bank 15
// - direct operand, bank flag set: bank from selector, legal 0, 1, 15
// - indirect through index-based pairs always uses bank 0
// - flag-area operands limited to FB0H-FBFH and FF0H-FFFH
// - flag and port area operands use bank 15; port area FC0H-FFFH
// - long branch and call addresses lie in 0000H-1F7FH
// - relative targets reach PC-15 to PC-1 and PC+2 to PC+16
// - in-block target is 12 bits; PC bit 12 picks the block
// - short call target is 11 bits, reaching 0000H-07FFH only
// - table entry address is even, from 20H to 7FH
// - skip adds 0, 1 for 1-2 byte, 2 for 3-byte instruction
// - skipping a table indirect call costs exactly one machine cycle
// - machine cycle is one cpu clock; three rates set by divider control

module oaddr_core (
   input wire aclk,
   input wire aresetn,
   input wire [31:0] awaddr,
   input wire awvalid,
   output reg awready,
   input wire [31:0] wdata,
   input wire [3:0] wstrb,
   input wire wvalid,
   output reg wready,
   output reg [1:0] bresp,
   output reg bvalid,
   input wire bready,
   input wire [31:0] araddr,
   input wire arvalid,
   output reg arready,
   output reg [31:0] rdata,
   output reg [1:0] rresp,
   output reg rvalid,
   input wire rready
);
   // nibble i of wreg: 0 X, 1 A, 2 B, 3 C, 4 D, 5 E, 6 H, 7 L
   reg [31:0] wreg;
   reg carry;
   reg bank_enable_flag;
   reg [3:0] bank_select_value;
   reg [1:0] cpu_clock_divider_control;
   reg [12:0] pc;
   reg [3:0] req_kind;
   reg [12:0] req_oper;
   reg req_pend;
   reg [12:0] res_addr;
   reg [3:0] res_bank;
   reg res_legal;
   reg res_data;
   reg [1:0] skip_cnt;
   reg [7:0] div_cnt;
   reg [31:0] waddr_q;
   reg [31:0] wdata_q;
   reg [3:0] wstrb_q;

   wire wr_fire;
   wire [31:0] w_pair;
   wire [31:0] w_ctrl;
   wire [31:0] w_pc;
   wire [31:0] w_req;
   wire [31:0] w_res;
   wire [31:0] w_skip;
   wire [32:0] wr_sel;
   wire [32:0] rd_sel;
   wire [31:0] wr_m;
   wire [31:0] pair_m;
   wire [7:0] hl;
   wire [7:0] de;
   wire [7:0] dl;
   wire [3:0] dec_bank;
   wire [12:0] dec_addr;
   wire dec_legal;
   wire dec_data;
   wire [7:0] div_max;
   wire tick;
   wire bit_in;
   reg [1:0] next_skip;

   function [31:0] merge_strb;
      input [31:0] old;
      input [31:0] nw;
      input [3:0] strb;
      integer i;
      begin
         merge_strb = old;
         for (i = 0; i < 4; i = i + 1) begin
            if (strb[i]) begin
               merge_strb[i*8 +: 8] = nw[i*8 +: 8];
            end
         end
      end
   endfunction

   // pair byte p holds register 2p high and 2p+1 low; its own inverse
   function [31:0] swap_nib;
      input [31:0] v;
      integer i;
      begin
         swap_nib = v;
         for (i = 0; i < 4; i = i + 1) begin
            swap_nib[i*8 +: 4] = v[i*8+4 +: 4];
            swap_nib[i*8+4 +: 4] = v[i*8 +: 4];
         end
      end
   endfunction

   // bit 32 flags an unmapped address
   function [32:0] sel_word;
      input [31:0] a;
      input [31:0] r_wreg;
      input [31:0] r_pair;
      input [31:0] r_ctrl;
      input [31:0] r_pc;
      input [31:0] r_req;
      input [31:0] r_res;
      input [31:0] r_skip;
      begin
         if (a == `OA_OFF_WREG) begin
            sel_word = {1'b0, r_wreg};
         end else if (a == `OA_OFF_PAIR) begin
            sel_word = {1'b0, r_pair};
         end else if (a == `OA_OFF_CTRL) begin
            sel_word = {1'b0, r_ctrl};
         end else if (a == `OA_OFF_PC) begin
            sel_word = {1'b0, r_pc};
         end else if (a == `OA_OFF_REQ) begin
            sel_word = {1'b0, r_req};
         end else if (a == `OA_OFF_RES) begin
            sel_word = {1'b0, r_res};
         end else if (a == `OA_OFF_BOP) begin
            sel_word = {1'b0, 32'h00000000};
         end else if (a == `OA_OFF_SKIP) begin
            sel_word = {1'b0, r_skip};
         end else begin
            sel_word = {1'b1, 32'h00000000};
         end
      end
   endfunction

   assign w_pair = swap_nib(wreg);
   assign w_ctrl = {22'h000000, cpu_clock_divider_control, bank_select_value, 2'h0, bank_enable_flag, carry};
   assign w_pc = {19'h00000, pc};
   assign w_req = {12'h000, req_kind, 3'h0, req_oper};
   assign w_res = {6'h00, res_data, res_legal, 4'h0, res_bank, 3'h0, res_addr};
   assign w_skip = {27'h0000000, skip_cnt != `OA_S_NONE, 2'h0, skip_cnt};

   assign wr_sel = sel_word(waddr_q, wreg, w_pair, w_ctrl, w_pc, w_req, w_res, w_skip);
   assign rd_sel = sel_word(araddr, wreg, w_pair, w_ctrl, w_pc, w_req, w_res, w_skip);
   assign wr_m = merge_strb(wr_sel[31:0], wdata_q, wstrb_q);
   assign pair_m = swap_nib(wr_m);

   // both halves of the write are held and no response is outstanding
   assign wr_fire = !awready && !wready && !bvalid;

   assign hl = w_pair[31:24];
   assign de = w_pair[23:16];
   assign dl = {wreg[19:16], wreg[31:28]};
   assign bit_in = wreg[{wdata_q[`OA_BOP_SEL_LO +: 3], wdata_q[`OA_BOP_BIT_LO +: 2]}];

   assign div_max = (cpu_clock_divider_control == `OA_PCC_FAST) ? `OA_DIV_FAST :
                    (cpu_clock_divider_control == `OA_PCC_MID) ? `OA_DIV_MID : `OA_DIV_SLOW;
   assign tick = (div_cnt == div_max);

   oaddr_decode u_dec (
      .kind(req_kind),
      .oper(req_oper),
      .pc(pc),
      .bank_enable_flag(bank_enable_flag),
      .bank_select_value(bank_select_value),
      .hl(hl),
      .de(de),
      .dl(dl),
      .bank(dec_bank),
      .addr(dec_addr),
      .legal(dec_legal),
      .is_data(dec_data)
   );

   // extra machine cycles for a skip request
   always @* begin
      if (wdata_q[`OA_SKIP_TABLE_INDIRECT_CALL]) begin
         next_skip = `OA_S_SHORT;
      end else if (wdata_q[1:0] == `OA_LEN_NONE) begin
         next_skip = `OA_S_NONE;
      end else if (wdata_q[1:0] == `OA_LEN_LONG) begin
         next_skip = `OA_S_LONG;
      end else begin
         next_skip = `OA_S_SHORT;
      end
   end

   // write address and data channels, taken in either order
   always @(posedge aclk) begin
      if (!aresetn) begin
         awready <= 1'b1;
         wready <= 1'b1;
         bvalid <= 1'b0;
         bresp <= `OA_RESP_OKAY;
         waddr_q <= 32'h00000000;
         wdata_q <= 32'h00000000;
         wstrb_q <= 4'h0;
      end else begin
         if (awvalid && awready) begin
            waddr_q <= awaddr;
            awready <= 1'b0;
         end
         if (wvalid && wready) begin
            wdata_q <= wdata;
            wstrb_q <= wstrb;
            wready <= 1'b0;
         end
         if (wr_fire) begin
            bvalid <= 1'b1;
            bresp <= wr_sel[32] ? `OA_RESP_SLVERR : `OA_RESP_OKAY;
         end
         if (bvalid && bready) begin
            bvalid <= 1'b0;
            awready <= 1'b1;
            wready <= 1'b1;
         end
      end
   end

   // read channel answers one cycle after the address is taken
   always @(posedge aclk) begin
      if (!aresetn) begin
         arready <= 1'b1;
         rvalid <= 1'b0;
         rdata <= 32'h00000000;
         rresp <= `OA_RESP_OKAY;
      end else begin
         if (arvalid && arready) begin
            arready <= 1'b0;
            rvalid <= 1'b1;
            rdata <= rd_sel[31:0];
            rresp <= rd_sel[32] ? `OA_RESP_SLVERR : `OA_RESP_OKAY;
         end
         if (rvalid && rready) begin
            rvalid <= 1'b0;
            arready <= 1'b1;
         end
      end
   end

   // machine-cycle divider; after a rate change a count above the new limit restarts at zero
   always @(posedge aclk) begin
      if (!aresetn) begin
         div_cnt <= 8'h00;
      end else if (tick || div_cnt > div_max) begin
         div_cnt <= 8'h00;
      end else begin
         div_cnt <= div_cnt + 8'h01;
      end
   end

   // register file and its side effects
   always @(posedge aclk) begin
      if (!aresetn) begin
         wreg <= 32'h00000000;
         carry <= 1'b0;
         bank_enable_flag <= 1'b0;
         bank_select_value <= `OA_BANK0;
         cpu_clock_divider_control <= `OA_PCC_SLOW;
         pc <= 13'h0000;
         req_kind <= `OA_K_DIRECT;
         req_oper <= 13'h0000;
         req_pend <= 1'b0;
         res_addr <= 13'h0000;
         res_bank <= `OA_BANK0;
         res_legal <= 1'b0;
         res_data <= 1'b0;
         skip_cnt <= `OA_S_NONE;
      end else begin
         req_pend <= 1'b0;
         if (req_pend) begin
            res_addr <= dec_addr;
            res_bank <= dec_bank;
            res_legal <= dec_legal;
            res_data <= dec_data;
         end
         // stall cycles drain one per machine cycle
         if (tick && skip_cnt != `OA_S_NONE) begin
            skip_cnt <= skip_cnt - 2'h1;
         end
         if (wr_fire && !wr_sel[32]) begin
            if (waddr_q == `OA_OFF_WREG) begin
               wreg <= wr_m;
            end else if (waddr_q == `OA_OFF_PAIR) begin
               wreg <= pair_m;
            end else if (waddr_q == `OA_OFF_CTRL) begin
               carry <= wr_m[`OA_CTL_CY];
               bank_enable_flag <= wr_m[`OA_CTL_MBE];
               // an illegal bank value is dropped, the old bank stays
               if (wr_m[`OA_CTL_MBS_LO +: 4] == `OA_BANK0 ||
                   wr_m[`OA_CTL_MBS_LO +: 4] == `OA_BANK1 ||
                   wr_m[`OA_CTL_MBS_LO +: 4] == `OA_BANK15) begin
                  bank_select_value <= wr_m[`OA_CTL_MBS_LO +: 4];
               end
               if (wr_m[`OA_CTL_PCC_LO +: 2] != `OA_PCC_BAD) begin
                  cpu_clock_divider_control <= wr_m[`OA_CTL_PCC_LO +: 2];
               end
            end else if (waddr_q == `OA_OFF_PC) begin
               pc <= wr_m[12:0];
            end else if (waddr_q == `OA_OFF_REQ) begin
               req_oper <= wr_m[12:0];
               req_kind <= wr_m[`OA_REQ_KIND_LO +: 4];
               req_pend <= 1'b1;
            end else if (waddr_q == `OA_OFF_BOP) begin
               if (wdata_q[1:0] == `OA_BOP_LD) begin
                  carry <= bit_in;
               end else if (wdata_q[1:0] == `OA_BOP_AND) begin
                  carry <= carry & bit_in;
               end else if (wdata_q[1:0] == `OA_BOP_OR) begin
                  carry <= carry | bit_in;
               end else begin
                  carry <= carry ^ bit_in;
               end
            end else if (waddr_q == `OA_OFF_SKIP) begin
               skip_cnt <= next_skip;
            end
         end
      end
   end
endmodule

// ==== tb/coa_checker_assertions.sv ====
`timescale 1ns/1ns
`include "oaddr_consts.vh"

module coa_checker (
   input logic aclk,
   input logic aresetn,
   input logic [31:0] awaddr,
   input logic awvalid,
   input logic awready,
   input logic wvalid,
   input logic wready,
   input logic [1:0] bresp,
   input logic bvalid,
   input logic [31:0] araddr,
   input logic arvalid,
   input logic arready,
   input logic [31:0] rdata,
   input logic [1:0] rresp,
   input logic rvalid,
   input logic rready
);
   logic [31:0] ra;
   logic wbad;
   wire rtk = arvalid && arready;
   wire rbad = araddr[1:0] != 2'h0 || araddr > 32'h1C;
   wire [3:0] bk = rdata[19:16];
   wire [3:0] cb = rdata[7:4];

   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);

   // remember which register an answer belongs to
   always @(posedge aclk) begin
      if (rtk)
         ra <= araddr;
      if (awvalid && awready)
         wbad <= awaddr[1:0] != 2'h0 || awaddr > 32'h1C;
   end

   property p_rd_lat;
      rtk |=> rvalid && !arready;
   endproperty
   a_rd_lat: assert property (p_rd_lat) else $error("read answer not one cycle after request");

   property p_wr_lat;
      awvalid && awready && wvalid && wready |=> !bvalid ##1 bvalid;
   endproperty
   a_wr_lat: assert property (p_wr_lat) else $error("write answer not two edges after request");

   property p_ar_low;
      rvalid |-> !arready;
   endproperty
   a_ar_low: assert property (p_ar_low) else $error("read accepted while answer pending");

   property p_aw_low;
      bvalid |-> !awready && !wready;
   endproperty
   a_aw_low: assert property (p_aw_low) else $error("write accepted while answer pending");

   property p_unm_rd;
      rtk && rbad |=> rresp == `OA_RESP_SLVERR && rdata == 32'h0;
   endproperty
   a_unm_rd: assert property (p_unm_rd) else $error("unmapped read not refused");

   property p_unm_wr;
      bvalid && wbad |-> bresp == `OA_RESP_SLVERR;
   endproperty
   a_unm_wr: assert property (p_unm_wr) else $error("unmapped write not refused");

   property p_bop;
      rtk && araddr == `OA_OFF_BOP |=> rdata == 32'h0 && rresp == `OA_RESP_OKAY;
   endproperty
   a_bop: assert property (p_bop) else $error("bit operation port reads nonzero");

   property p_skip;
      rvalid && ra == `OA_OFF_SKIP |-> rdata[4] == (rdata[1:0] != 2'h0) && rdata[1:0] != 2'h3;
   endproperty
   a_skip: assert property (p_skip) else $error("skip count or busy inconsistent");

   property p_ctrl;
      rvalid && ra == `OA_OFF_CTRL |-> cb inside {4'h0, 4'h1, 4'hF} && rdata[9:8] != 2'h3;
   endproperty
   a_ctrl: assert property (p_ctrl) else $error("illegal bank or divider held");

   property p_res;
      rvalid && ra == `OA_OFF_RES && rdata[25] |-> rdata[12] == 1'b0 && rdata[11:8] == bk;
   endproperty
   a_res: assert property (p_res) else $error("data address bank field mismatch");

   property p_res_bk;
      rvalid && ra == `OA_OFF_RES && rdata[25] && rdata[24] |-> bk inside {4'h0, 4'h1, 4'hF};
   endproperty
   a_res_bk: assert property (p_res_bk) else $error("legal data access in bad bank");
endmodule

bind oaddr_core coa_checker u_chk (
   .aclk, .aresetn, .awaddr, .awvalid, .awready, .wvalid, .wready, .bresp, .bvalid,
   .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready
);

// ==== tb/test_cpu_operand_addressing.sv ====
`timescale 1ns/1ns
`include "oaddr_consts.vh"

module test_cpu_operand_addressing;
   logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, bb;
   logic [31:0] awaddr, wdata, araddr, seed, wreg, ctrl, v, g;
   logic [3:0] wstrb, k;
   logic [12:0] pc, op;
   logic [1:0] r, s;
   wire awready, wready, bvalid, arready, rvalid;
   wire [1:0] bresp, rresp;
   wire [31:0] rdata;
   integer fails, n_checks, i, j, t, dv;
   logic [19:0] cs [0:35] = '{20'h0007F, 20'h00080, 20'h000FF, 20'h00100, 20'h10000,
      20'h20000, 20'h20001, 20'h30FAF, 20'h30FB0, 20'h30FBF, 20'h30FC0, 20'h30FEF,
      20'h30FF0, 20'h30FFF, 20'h40FBF, 20'h40FC0, 20'h40FFF, 20'h51F7F, 20'h51F80,
      20'h600F0, 20'h600F1, 20'h600FF, 20'h60100, 20'h60101, 20'h60102, 20'h60110,
      20'h60111, 20'h70FFF, 20'h807FF, 20'h80800, 20'h9001E, 20'h90020, 20'h90021,
      20'h9007E, 20'h9007F, 20'h90080};

   oaddr_core dut (
      .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
      .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
      .rready
   );

   initial begin
      aclk = 1'b0;
      forever #50 aclk = ~aclk;
   end

   function logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   // pair view puts the lower-numbered register in the high nibble
   function logic [31:0] swp(input logic [31:0] w);
      return ((w & 32'h0F0F0F0F) << 4) | ((w >> 4) & 32'h0F0F0F0F);
   endfunction

   task wrap_up;
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task chk(input string nm, input logic [31:0] sn, input logic [31:0] xp);
      n_checks++;
      if (sn !== xp) begin
         fails++;
         $display("BAD %s exp %h got %h", nm, xp, sn);
      end
   endtask

   task wr(input logic [31:0] a, input logic [31:0] d);
      integer n;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (n = 0; n < 40; n++) begin
         @(posedge aclk);
         if (awready)
            awvalid <= 1'b0;
         if (wready)
            wvalid <= 1'b0;
         if (bvalid) begin
            r = bresp;
            bready <= 1'b0;
            return;
         end
      end
      fails++;
      wrap_up;
   endtask

   task rd(input logic [31:0] a);
      integer n;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (n = 0; n < 40; n++) begin
         @(posedge aclk);
         if (arready)
            arvalid <= 1'b0;
         if (rvalid) begin
            g = rdata;
            r = rresp;
            rready <= 1'b0;
            return;
         end
      end
      fails++;
      wrap_up;
   endtask

   task dec(input logic [3:0] kd, input logic [12:0] o);
      logic [3:0] b;
      logic [12:0] ad;
      logic [13:0] dd;
      logic lg;
      logic [31:0] m;
      b = 4'h0;
      ad = o;
      lg = 1'b1;
      // no wrap across the ends of program space
      dd = {1'b0, o} - {1'b0, pc};
      case (kd)
         `OA_K_DIRECT: begin
            b = ctrl[1] ? ctrl[7:4] : {4{o[7]}};
            lg = o < 13'h0100;
         end
         `OA_K_IND_HL: begin
            b = ctrl[1] ? ctrl[7:4] : 4'h0;
            ad = {5'h00, wreg[27:24], wreg[31:28]};
         end
         `OA_K_IND_DE: ad = {5'h00, wreg[19:16], o[0] ? wreg[31:28] : wreg[23:20]};
         `OA_K_FMEM: begin
            b = 4'hF;
            lg = (o >= 13'h0FB0 && o <= 13'h0FBF) || (o >= 13'h0FF0 && o <= 13'h0FFF);
         end
         `OA_K_PMEM: begin
            b = 4'hF;
            lg = o >= 13'h0FC0 && o <= 13'h0FFF;
         end
         `OA_K_ABS: lg = o <= `OA_PROG_MAX;
         `OA_K_REL: lg = dd >= 14'h3FF1 || (dd >= 14'h0002 && dd <= 14'h0010);
         `OA_K_CADDR: begin
            ad = {pc[12], o[11:0]};
            lg = ad <= `OA_PROG_MAX && !o[12];
         end
         `OA_K_FADDR: begin
            lg = o <= 13'h07FF;
            ad = {2'h0, o[10:0]};
         end
         default: lg = o >= 13'h0020 && o <= 13'h007F && !o[0];
      endcase
      if (kd < 4'h5)
         ad = {1'b0, b, ad[7:0]};
      m = kd < 4'h5 ? 32'h030F1FFF : 32'h03001FFF;
      wr(`OA_OFF_REQ, {12'h000, kd, 3'h0, o});
      rd(`OA_OFF_RES);
      chk("res", g & m, {6'h00, kd < 4'h5, lg, 4'h0, b, 3'h0, ad} & m);
   endtask

   initial begin
      seed = 32'h0001155E;
      fails = 0;
      n_checks = 0;
      {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
      {awaddr, wdata, araddr} = 96'h0;
      wstrb = 4'hF;
      {wreg, ctrl, pc} = 77'h0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      for (i = 0; i < 8; i++) begin
         rd(i * 4);
         chk("rst", g, 32'h0);
         chk("rresp", r, `OA_RESP_OKAY);
      end
      rd(32'h20);
      chk("unm_rd", r, `OA_RESP_SLVERR);
      wr(32'h2, 32'hFFFF);
      chk("unm_wr", r, `OA_RESP_SLVERR);
      rd(`OA_OFF_WREG);
      chk("unm_fx", g, 32'h0);
      for (i = 0; i < 4; i++) begin
         wreg = rnd();
         wr(`OA_OFF_WREG, wreg);
         chk("bresp", r, `OA_RESP_OKAY);
         rd(`OA_OFF_PAIR);
         chk("pair", g, swp(wreg));
         v = rnd();
         wr(`OA_OFF_PAIR, v);
         wreg = swp(v);
         // a partial write must keep the unstrobed bytes
         v = rnd();
         wstrb <= 4'h6;
         wr(`OA_OFF_WREG, v);
         wstrb <= 4'hF;
         wreg[23:8] = v[23:8];
         rd(`OA_OFF_WREG);
         chk("wreg", g, wreg);
      end
      for (i = 0; i < 16; i++) begin
         v = rnd();
         v = {22'h0, v[9:8], i[3:0], 2'h0, v[1:0]};
         wr(`OA_OFF_CTRL, v);
         ctrl[1:0] = v[1:0];
         if (v[7:4] inside {4'h0, 4'h1, 4'hF})
            ctrl[7:4] = v[7:4];
         if (v[9:8] != 2'h3)
            ctrl[9:8] = v[9:8];
         rd(`OA_OFF_CTRL);
         chk("ctrl", g & 32'h3F3, ctrl);
      end
      for (i = 0; i < 16; i++) begin
         wreg = rnd();
         wr(`OA_OFF_WREG, wreg);
         v = rnd();
         v = {25'h0, v[6:2], i[1:0]};
         bb = wreg[{v[4:2], v[6:5]}];
         case (v[1:0])
            `OA_BOP_LD: ctrl[0] = bb;
            `OA_BOP_AND: ctrl[0] = ctrl[0] & bb;
            `OA_BOP_OR: ctrl[0] = ctrl[0] | bb;
            default: ctrl[0] = ctrl[0] ^ bb;
         endcase
         wr(`OA_OFF_BOP, v);
         rd(`OA_OFF_CTRL);
         chk("carry", g & 32'h3F3, ctrl);
      end
      pc = 13'h0100;
      wr(`OA_OFF_PC, {19'h0, pc});
      for (j = 0; j < 4; j++) begin
         ctrl[1] = j != 0;
         ctrl[7:4] = j == 3 ? 4'hF : (j == 2 ? 4'h1 : 4'h0);
         wr(`OA_OFF_CTRL, ctrl);
         for (i = 0; i < 36; i++)
            dec(cs[i][19:16], cs[i][12:0]);
      end
      for (i = 0; i < 60; i++) begin
         v = rnd();
         pc = v[12:0];
         wr(`OA_OFF_PC, {19'h0, pc});
         ctrl[1] = v[16];
         ctrl[7:4] = v[17] ? 4'hF : {3'h0, v[18]};
         wr(`OA_OFF_CTRL, ctrl);
         wreg = rnd();
         wr(`OA_OFF_WREG, wreg);
         v = rnd();
         k = v[19:16] % 10;
         op = v[12:0];
         case (k)
            4'h0: op[12:9] = 4'h0;
            4'h1: op = 13'h0;
            4'h2: op[12:1] = 12'h0;
            4'h3, 4'h4: op = {5'h0F, v[7:0]};
            4'h6: op = pc + v[4:0] - 13'h0010;
            4'h7: op[12] = 1'b0;
            default: ;
         endcase
         dec(k, op);
      end
      for (j = 0; j < 3; j++) begin
         ctrl[9:8] = j[1:0];
         wr(`OA_OFF_CTRL, ctrl);
         dv = j == 0 ? 64 : (j == 1 ? 16 : 4);
         for (i = 0; i < 8; i++) begin
            s = i[2] ? 2'h1 : (i[1:0] == 2'h0 ? 2'h0 : (i[1:0] == 2'h3 ? 2'h2 : 2'h1));
            wr(`OA_OFF_SKIP, {29'h0, i[2:0]});
            t = $time;
            rd(`OA_OFF_SKIP);
            chk("s_now", g[1:0] == s || (s != 2'h0 && g[1:0] == s - 2'h1), 1);
            for (k = 0; k < 15 && g[4]; k++)
               repeat (10) rd(`OA_OFF_SKIP);
            t = ($time - t) / 100;
            chk("s_time", t <= s * dv + 40 && t + dv >= s * dv, 1);
         end
      end
      @(posedge aclk);
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      rd(`OA_OFF_CTRL);
      chk("rst2", g, 32'h0);
      wrap_up;
   end
endmodule
